/* File: hdl/ewc_pkg.sv */
// Package for the energy watch power control block
package ewc_pkg;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [4:0] EWC_CTRL_ADDR = 5'h1d;
    localparam int EWC_EN_BIT = 15;
    localparam int EWC_AUTO_WAKE_BIT = 14;
    localparam int EWC_AUTO_SLEEP_BIT = 13;
    localparam int EWC_MAN_BIT = 12;
    localparam int EWC_BURST_DIS_BIT = 11;
    localparam int EWC_PWR_BIT = 10;
    localparam int EWC_ERR_HIT_BIT = 9;
    localparam int EWC_DATA_HIT_BIT = 8;
    localparam int EWC_ERR_THR_LSB = 4;
    localparam int EWC_DATA_THR_LSB = 0;
    localparam logic [3:0] EWC_THR_RESET = 4'h1;
    localparam logic EWC_AUTO_RESET = 1'b1;
    // ****************************************
    // Timing
    // ****************************************
    localparam int EWC_CLK_HZ = 10000000;
    localparam int EWC_IDLE_S = 2;
    localparam int EWC_IDLE_CYCLES = EWC_IDLE_S * EWC_CLK_HZ;
    localparam logic [2:0] EWC_BURST_LEN = 3'h4;

    typedef struct packed {
        logic enable;
        logic auto_wake;
        logic auto_sleep;
        logic burst_dis;
        logic [3:0] err_thr;
        logic [3:0] data_thr;
    } ewc_cfg_s;

    typedef enum logic [1:0] {
        EWC_DOWN = 2'b01,
        EWC_UP = 2'b10
    } ewc_state_e;
endpackage : ewc_pkg

/* File: hdl/ewc_pulse_gen.sv */
// Energy detect pulse burst generator
`timescale 1ns/10ps
module ewc_pulse_gen
    import ewc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    input wire logic burst_dis,
    // Pulse out
    output logic pulse
);
    logic [2:0] left_q, left_d;
    logic pulse_q, pulse_d;

    always_comb
    begin
        left_d = left_q;
        pulse_d = 1'b0;
        if (start)
        begin
            left_d = burst_dis ? 3'h1 : EWC_BURST_LEN;
        end
        else if (left_q != 3'h0)
        begin
            pulse_d = 1'b1;
            left_d = left_q - 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            left_q <= 3'h0;
            pulse_q <= 1'b0;
        end
        else
        begin
            left_q <= left_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;
endmodule : ewc_pulse_gen

/* File: hdl/ewc_top.sv */
// Energy watch power control: register, counters and power state
`timescale 1ns/10ps
module ewc_top
    import ewc_pkg::*;
#(
    parameter int IDLE_CYCLES = EWC_IDLE_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Line events
    input wire logic line_energy,
    input wire logic data_event,
    input wire logic error_event,
    // Line driver
    output logic line_driver_on,
    output logic energy_pulse
);
    // ****************************************
    // Register state
    // ****************************************
    ewc_cfg_s cfg_q, cfg_d;
    ewc_state_e st_q, st_d;
    logic err_hit_q, err_hit_d;
    logic data_hit_q, data_hit_d;
    logic [3:0] data_cnt_q, data_cnt_d;
    logic [3:0] err_cnt_q, err_cnt_d;
    logic [24:0] idle_q, idle_d;
    logic [15:0] rdata_q, rdata_d;
    logic drv_q, drv_d;
    logic sel, man_wr, data_reached, err_reached, wake;
    localparam ewc_cfg_s CFG_RST = '{1'b0, EWC_AUTO_RESET, EWC_AUTO_RESET, 1'b0, EWC_THR_RESET,
                                     EWC_THR_RESET};

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == 4'hf) ? v : v + 4'h1;
    endfunction : sat_inc

    function automatic logic [15:0] pack_reg(input ewc_cfg_s c, input logic pwr,
                                             input logic eh, input logic dh);
        pack_reg = {c.enable, c.auto_wake, c.auto_sleep, 1'b0, c.burst_dis, pwr, eh, dh,
                    c.err_thr, c.data_thr};
    endfunction : pack_reg

    always_comb
    begin
        sel = (reg_addr == EWC_CTRL_ADDR);
        man_wr = reg_wr && sel && reg_wdata[EWC_MAN_BIT];
        data_reached = sat_inc(data_cnt_q) >= cfg_q.data_thr;
        err_reached = sat_inc(err_cnt_q) >= cfg_q.err_thr;
    end

    // ****************************************
    // Configuration writes
    // ****************************************
    always_comb
    begin
        cfg_d = cfg_q;
        if (reg_wr && sel)
        begin
            cfg_d.enable = reg_wdata[EWC_EN_BIT];
            cfg_d.auto_wake = reg_wdata[EWC_AUTO_WAKE_BIT];
            cfg_d.auto_sleep = reg_wdata[EWC_AUTO_SLEEP_BIT];
            cfg_d.burst_dis = reg_wdata[EWC_BURST_DIS_BIT];
            cfg_d.err_thr = reg_wdata[EWC_ERR_THR_LSB +: 4];
            cfg_d.data_thr = reg_wdata[EWC_DATA_THR_LSB +: 4];
        end
    end

    // ****************************************
    // Counters, flags and power state
    // ****************************************
    always_comb
    begin
        data_cnt_d = data_cnt_q;
        err_cnt_d = err_cnt_q;
        idle_d = idle_q;
        err_hit_d = err_hit_q;
        data_hit_d = data_hit_q;
        st_d = st_q;
        wake = 1'b0;
        if (reg_rd && sel)
        begin
            err_hit_d = 1'b0;
            data_hit_d = 1'b0;
        end
        if (!cfg_q.enable)
        begin
            data_cnt_d = 4'h0;
            err_cnt_d = 4'h0;
            idle_d = 25'h0;
            st_d = EWC_UP;
        end
        else
        begin
            if (data_event)
            begin
                idle_d = 25'h0;
                data_cnt_d = sat_inc(data_cnt_q);
                if (data_reached)
                begin
                    data_hit_d = 1'b1;
                end
            end
            else if (idle_q >= 25'(IDLE_CYCLES - 1))
            begin
                idle_d = 25'h0;
                data_cnt_d = 4'h0;
                err_cnt_d = 4'h0;
            end
            else
            begin
                idle_d = idle_q + 25'h1;
            end
            if (error_event)
            begin
                err_cnt_d = sat_inc(err_cnt_q);
                if (err_reached)
                begin
                    err_hit_d = 1'b1;
                end
            end
            if (man_wr)
            begin
                st_d = (st_q == EWC_UP) ? EWC_DOWN : EWC_UP;
            end
            else
            begin
                case (st_q)
                    EWC_DOWN:
                    begin
                        if (cfg_q.auto_wake && data_event && data_reached)
                        begin
                            st_d = EWC_UP;
                        end
                    end
                    EWC_UP:
                    begin
                        if (cfg_q.auto_sleep && !line_energy)
                        begin
                            st_d = EWC_DOWN;
                        end
                    end
                    default:
                    begin
                        st_d = EWC_DOWN;
                    end
                endcase
            end
            wake = (st_q == EWC_DOWN) && (st_d == EWC_UP);
        end
        drv_d = (st_d == EWC_UP);
        rdata_d = pack_reg(cfg_d, st_d == EWC_UP, err_hit_d, data_hit_d);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cfg_q <= CFG_RST;
            st_q <= EWC_UP;
            err_hit_q <= 1'b0;
            data_hit_q <= 1'b0;
            data_cnt_q <= 4'h0;
            err_cnt_q <= 4'h0;
            idle_q <= 25'h0;
            rdata_q <= pack_reg(CFG_RST, 1'b1, 1'b0, 1'b0);
            drv_q <= 1'b1;
        end
        else
        begin
            cfg_q <= cfg_d;
            st_q <= st_d;
            err_hit_q <= err_hit_d;
            data_hit_q <= data_hit_d;
            data_cnt_q <= data_cnt_d;
            err_cnt_q <= err_cnt_d;
            idle_q <= idle_d;
            rdata_q <= rdata_d;
            drv_q <= drv_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign line_driver_on = drv_q;

    ewc_pulse_gen u_pulse (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(wake),
        .burst_dis(cfg_q.burst_dis),
        .pulse(energy_pulse)
    );

    // ****************************************
    // Assertions
    // ****************************************
    property p_disabled_up;
        @(posedge clk) disable iff (sys_rst) !cfg_q.enable |=> st_q == EWC_UP;
    endproperty
    a_disabled_up: assert property (p_disabled_up) else $error("state not up when off");

    property p_auto_wake;
        @(posedge clk) disable iff (sys_rst)
            cfg_q.enable && st_q == EWC_DOWN && cfg_q.auto_wake && data_event && data_reached
            && !man_wr |=> st_q == EWC_UP;
    endproperty
    a_auto_wake: assert property (p_auto_wake) else $error("auto wake missed");

    property p_auto_sleep;
        @(posedge clk) disable iff (sys_rst)
            cfg_q.enable && st_q == EWC_UP && cfg_q.auto_sleep && !line_energy && !man_wr
            |=> st_q == EWC_DOWN;
    endproperty
    a_auto_sleep: assert property (p_auto_sleep) else $error("auto sleep missed");

    property p_manual;
        @(posedge clk) disable iff (sys_rst)
            cfg_q.enable && man_wr |=> st_q != $past(st_q);
    endproperty
    a_manual: assert property (p_manual) else $error("manual toggle missed");

    property p_burst;
        @(posedge clk) disable iff (sys_rst)
            wake && !cfg_q.burst_dis |=> ##1 energy_pulse [*4] ##1 !energy_pulse;
    endproperty
    a_burst: assert property (p_burst) else $error("burst length wrong");

    property p_single;
        @(posedge clk) disable iff (sys_rst)
            wake && cfg_q.burst_dis |=> ##1 energy_pulse ##1 !energy_pulse;
    endproperty
    a_single: assert property (p_single) else $error("single pulse wrong");

    property p_pwr_bit;
        @(posedge clk) disable iff (sys_rst)
            reg_rdata[EWC_PWR_BIT] == (st_q == EWC_UP);
    endproperty
    a_pwr_bit: assert property (p_pwr_bit) else $error("power bit wrong");

    property p_err_hit;
        @(posedge clk) disable iff (sys_rst)
            cfg_q.enable && error_event && err_reached |=> err_hit_q;
    endproperty
    a_err_hit: assert property (p_err_hit) else $error("error flag not set");

    property p_data_hit;
        @(posedge clk) disable iff (sys_rst)
            cfg_q.enable && data_event && data_reached |=> data_hit_q;
    endproperty
    a_data_hit: assert property (p_data_hit) else $error("data flag not set");

    property p_cor;
        @(posedge clk) disable iff (sys_rst)
            reg_rd && sel && data_hit_q && !(cfg_q.enable && data_event)
            |-> reg_rdata[EWC_DATA_HIT_BIT] ##1 !data_hit_q;
    endproperty
    a_cor: assert property (p_cor) else $error("clear on read wrong");

    property p_idle;
        @(posedge clk) disable iff (sys_rst)
            cfg_q.enable && !data_event && idle_q >= 25'(IDLE_CYCLES - 1) |=> data_cnt_q == 4'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle clear missed");

    property p_thr_wr;
        @(posedge clk) disable iff (sys_rst)
            reg_wr && sel |=> cfg_q.data_thr == $past(reg_wdata[3:0]);
    endproperty
    a_thr_wr: assert property (p_thr_wr) else $error("threshold write lost");

    c_wake: cover property (@(posedge clk) wake);
    c_sleep: cover property (@(posedge clk) st_q == EWC_UP ##1 st_q == EWC_DOWN);
    c_err: cover property (@(posedge clk) err_hit_q);
    c_man: cover property (@(posedge clk) cfg_q.enable && man_wr);
endmodule : ewc_top

/* File: tb/ewc_mgmt_model.sv */
// Station management model driving the energy watch register port
`timescale 1ns/10ps
module ewc_mgmt_model
    import ewc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register access
    output logic reg_wr,
    output logic reg_rd,
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    // ****************************************
    // Bus cycles
    // ****************************************
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
    end

    // Crossover selection is not modelled, so software keeps it off here
    // Manual toggles are issued only when the sequence asks for them
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    // Data captured at the edge that takes the read
    task automatic rd(output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= EWC_CTRL_ADDR;
        @(posedge clk);
        d = reg_rdata;
        reg_rd <= 1'b0;
        reg_addr <= 5'h00;
    endtask : rd
endmodule : ewc_mgmt_model

/* File: tb/tb_top.sv */
// Self-checking testbench for the energy watch power control block
`timescale 1ns/10ps
module tb_top;
    import ewc_pkg::*;
    localparam int IDLE = 50;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic line_energy = 1'b1;
    logic data_event = 1'b0;
    logic error_event = 1'b0;
    logic reg_wr;
    logic reg_rd;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic line_driver_on;
    logic energy_pulse;
    logic [15:0] v;
    int bad_count = 0;
    int num_checks = 0;
    int pulses = 0;
    int p0;

    always #50 clk = ~clk;
    always @(posedge clk) if (energy_pulse === 1'b1) pulses <= pulses + 1;

    ewc_top #(.IDLE_CYCLES(IDLE)) ewc_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .line_energy(line_energy), .data_event(data_event), .error_event(error_event),
        .line_driver_on(line_driver_on), .energy_pulse(energy_pulse));
    ewc_mgmt_model ewc_mgmt_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rd_chk(input string n, input logic [15:0] e);
        ewc_mgmt_model_inst.rd(v);
        chk(n, e, v);
    endtask : rd_chk

    task automatic wait_drv(input logic val);
        for (int i = 0; i < 20 && line_driver_on !== val; i++) @(negedge clk);
        chk("line_driver_on", {15'h0000, val}, {15'h0000, line_driver_on});
    endtask : wait_drv

    task automatic events(input logic err, input int n);
        repeat (n)
        begin
            @(posedge clk);
            data_event <= ~err;
            error_event <= err;
            @(posedge clk);
            data_event <= 1'b0;
            error_event <= 1'b0;
        end
    endtask : events

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk("reset value", 16'h6411);
        wait_drv(1'b1);
    endtask : t_reset

    task automatic t_auto();
        ewc_mgmt_model_inst.wr(EWC_CTRL_ADDR, 16'he023);
        line_energy <= 1'b0;
        wait_drv(1'b0);
        rd_chk("cfg down", 16'he023);
        line_energy <= 1'b1;
        events(1'b0, 2);
        repeat (4) @(posedge clk);
        wait_drv(1'b0);
        p0 = pulses;
        events(1'b0, 1);
        wait_drv(1'b1);
        repeat (8) @(posedge clk);
        chk("burst", 16'h0004, 16'(pulses - p0));
        rd_chk("data hit", 16'he523);
        rd_chk("data cleared", 16'he423);
        events(1'b1, 2);
        rd_chk("error hit", 16'he623);
        rd_chk("error cleared", 16'he423);
        wait_drv(1'b1);
    endtask : t_auto

    task automatic t_manual();
        repeat (IDLE + 10) @(posedge clk);
        ewc_mgmt_model_inst.wr(EWC_CTRL_ADDR, 16'hd823);
        wait_drv(1'b0);
        rd_chk("manual down", 16'hc823);
        events(1'b0, 2);
        repeat (IDLE + 10) @(posedge clk);
        events(1'b0, 2);
        repeat (4) @(posedge clk);
        wait_drv(1'b0);
        p0 = pulses;
        events(1'b0, 1);
        wait_drv(1'b1);
        repeat (8) @(posedge clk);
        chk("single pulse", 16'h0001, 16'(pulses - p0));
        rd_chk("wake flags", 16'hcd23);
    endtask : t_manual

    task automatic t_unmapped_disable();
        ewc_mgmt_model_inst.wr(5'h1c, 16'h0000);
        rd_chk("unmapped", 16'hcc23);
        ewc_mgmt_model_inst.wr(EWC_CTRL_ADDR, 16'h0011);
        rd_chk("disabled", 16'h0411);
        ewc_mgmt_model_inst.wr(EWC_CTRL_ADDR, 16'h1011);
        repeat (3) @(posedge clk);
        wait_drv(1'b1);
        rd_chk("disabled manual", 16'h0411);
    endtask : t_unmapped_disable

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_auto();
        t_manual();
        t_unmapped_disable();
        wrap_up();
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule : tb_top
